// ---- verilog/tspc_pkg.sv ----
package tspc_pkg;
   // register indices on the plain register port
   localparam logic [2:0] ADDR_CTRL0    = 3'h0;
   localparam logic [2:0] ADDR_CTRL1    = 3'h1;
   localparam logic [2:0] ADDR_CMPA_LO  = 3'h2;
   localparam logic [2:0] ADDR_CMPA_HI  = 3'h3;
   localparam logic [2:0] ADDR_CMPP     = 3'h4;
   localparam logic [2:0] ADDR_COUNT_LO = 3'h5;
   localparam logic [2:0] ADDR_COUNT_HI = 3'h6;
   localparam logic [2:0] ADDR_STATUS   = 3'h7;

   // timer_control_zero field
   localparam int RUN_BIT = 3;

   // timer_control_one fields
   localparam int MODE_HI_BIT = 7;
   localparam int MODE_LO_BIT = 6;
   localparam int OUTF_HI_BIT = 5;
   localparam int OUTF_LO_BIT = 4;
   localparam int OLC_BIT     = 3;
   localparam int OINV_BIT    = 2;
   localparam int CSRC_BIT    = 1;
   localparam int CCLR_BIT    = 0;

   // status fields, write one to clear
   localparam int FLAG_A_BIT = 0;
   localparam int FLAG_P_BIT = 1;

   // mode select and output function codes
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_PULSE   = 2'h2;
   localparam logic [1:0] OUTF_SINGLE  = 2'h3;
   localparam logic [1:0] CAP_RISE     = 2'h0;
   localparam logic [1:0] CAP_FALL     = 2'h1;
   localparam logic [1:0] CAP_BOTH     = 2'h2;
   localparam logic [1:0] CAP_OFF      = 2'h3;

   // reset values
   localparam logic [7:0]  CTRL1_RESET = 8'h00;
   localparam logic [15:0] CMPA_RESET  = 16'h0000;
   localparam logic [7:0]  CMPP_RESET  = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;

   // timing: 20 MHz system clock, timer tick is system clock divided
   localparam int SYS_CLK_HZ    = 20000000;
   localparam int TICK_DIV      = 4;
   localparam int TICK_W        = 2;
   localparam int TIMER_CLK_HZ  = SYS_CLK_HZ / TICK_DIV;
   // flag delay after capture latch, half a timer clock
   localparam int HALF_TICK_CYC = SYS_CLK_HZ / (2 * TIMER_CLK_HZ);
   localparam int DLY_W         = 2;
endpackage : tspc_pkg

// ---- verilog/tspc_timer.sv ----
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module tspc_timer (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   // pins
   input  wire logic       ext_trigger_pin,
   input  wire logic       capture_pin,
   output logic            timer_out,
   // interrupt request pulse
   output logic            timer_irq
);
   import tspc_pkg::*;

   localparam int FLAG_D = HALF_TICK_CYC + 1;

   logic             counter_run_bit;
   logic             run_q;
   logic [7:0]       timer_control_one;
   logic [15:0]      compare_a_value;
   logic [7:0]       compare_p_value;
   logic [15:0]      count;
   logic [15:0]      next_count;
   logic [TICK_W-1:0] tick_cnt;
   logic             tick;
   logic             trig_s1;
   logic             trig_s2;
   logic             trig_s3;
   logic             cap_s1;
   logic             cap_s2;
   logic             cap_s3;
   logic             compare_a_flag;
   logic             compare_p_flag;
   logic [DLY_W-1:0] a_delay;
   logic [1:0]       mode_sel;
   logic [1:0]       out_func;
   logic             output_level_control;
   logic             output_invert;
   logic             capture_source_select;
   logic             pulse_mode;
   logic             cap_mode;
   logic             trig_rise;
   logic             src_now;
   logic             src_prev;
   logic             cap_event;
   logic             a_hit;
   logic             p_hit;
   logic             run_rise;
   logic             set_a;
   logic             set_p;
   logic             wr_ctrl0;
   logic             wr_status;
   logic [7:0]       next_rdata;

   // active capture edge for the selected edge type
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       now,
                                     input logic       prev);
      case (sel)
         CAP_RISE: edge_hit = now & ~prev;
         CAP_FALL: edge_hit = ~now & prev;
         CAP_BOTH: edge_hit = now ^ prev;
         default:  edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   // last count before compare P wraps; zero wraps at all ones
   function automatic logic [15:0] p_limit(input logic [7:0] cmp);
      p_limit = {cmp - 8'h01, 8'hFF};
   endfunction : p_limit

   assign mode_sel              = {timer_control_one[MODE_HI_BIT],
                                   timer_control_one[MODE_LO_BIT]};
   assign out_func              = {timer_control_one[OUTF_HI_BIT],
                                   timer_control_one[OUTF_LO_BIT]};
   assign output_level_control  = timer_control_one[OLC_BIT];
   assign output_invert         = timer_control_one[OINV_BIT];
   assign capture_source_select = timer_control_one[CSRC_BIT];

   assign pulse_mode = (mode_sel == MODE_PULSE)
                       && (out_func == OUTF_SINGLE);
   assign cap_mode   = (mode_sel == MODE_CAPTURE);

   assign wr_ctrl0  = reg_write && (reg_addr == ADDR_CTRL0);
   assign wr_status = reg_write && (reg_addr == ADDR_STATUS);

   // timer tick divider
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else begin
         tick <= (tick_cnt == TICK_W'(TICK_DIV - 1));
         if (tick_cnt == TICK_W'(TICK_DIV - 1)) begin
            tick_cnt <= '0;
         end else begin
            tick_cnt <= tick_cnt + TICK_W'(1);
         end
      end
   end

   // pin synchronisers, third stage only for edge detection
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_s3 <= 1'b0;
         cap_s1  <= 1'b0;
         cap_s2  <= 1'b0;
         cap_s3  <= 1'b0;
      end else begin
         trig_s1 <= ext_trigger_pin;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
         cap_s1  <= capture_pin;
         cap_s2  <= cap_s1;
         cap_s3  <= cap_s2;
      end
   end

   assign trig_rise = trig_s2 & ~trig_s3;
   assign src_now   = capture_source_select ? trig_s2 : cap_s2;
   assign src_prev  = capture_source_select ? trig_s3 : cap_s3;
   // latched from synced pin at once, well inside 1.5 ticks
   assign cap_event = cap_mode
                      && edge_hit(out_func, src_now, src_prev);

   assign next_count = count + 16'h0001;
   assign run_rise   = counter_run_bit && !run_q;
   assign a_hit      = pulse_mode && counter_run_bit && tick
                       && (next_count == compare_a_value);
   // compare P only acts in capture mode
   assign p_hit      = cap_mode && counter_run_bit && tick
                       && (count == p_limit(compare_p_value));

   // software control registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         timer_control_one <= CTRL1_RESET;
         compare_p_value   <= CMPP_RESET;
      end else if (reg_write) begin
         if (reg_addr == ADDR_CTRL1) begin
            timer_control_one <= reg_wdata;
         end
         if (reg_addr == ADDR_CMPP) begin
            compare_p_value <= reg_wdata;
         end
      end
   end

   // run bit: trigger set wins, then software, then compare A clear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         counter_run_bit <= 1'b0;
         run_q           <= 1'b0;
      end else begin
         run_q <= counter_run_bit;
         if (pulse_mode && trig_rise) begin
            counter_run_bit <= 1'b1;
         end else if (wr_ctrl0) begin
            counter_run_bit <= reg_wdata[RUN_BIT];
         end else if (a_hit) begin
            counter_run_bit <= 1'b0;
         end
      end
   end

   // counter
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         count <= COUNT_RESET;
      end else if (run_rise) begin
         count <= COUNT_RESET;
      end else if (p_hit) begin
         count <= COUNT_RESET;
      end else if (counter_run_bit && tick) begin
         count <= next_count;
      end
   end

   // compare A value, capture overrides a software write
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         compare_a_value <= CMPA_RESET;
      end else if (cap_event) begin
         compare_a_value <= count;
      end else if (reg_write && (reg_addr == ADDR_CMPA_LO)) begin
         compare_a_value[7:0] <= reg_wdata;
      end else if (reg_write && (reg_addr == ADDR_CMPA_HI)) begin
         compare_a_value[15:8] <= reg_wdata;
      end
   end

   // half tick delay from capture latch to compare A flag
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         a_delay <= '0;
      end else if (cap_event) begin
         a_delay <= DLY_W'(HALF_TICK_CYC);
      end else if (a_delay != '0) begin
         a_delay <= a_delay - DLY_W'(1);
      end
   end

   assign set_a = a_hit || (a_delay == DLY_W'(1));
   assign set_p = p_hit;

   // sticky flags, a set beats a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         compare_a_flag <= 1'b0;
         compare_p_flag <= 1'b0;
         timer_irq      <= 1'b0;
      end else begin
         timer_irq <= set_a || set_p;
         if (set_a) begin
            compare_a_flag <= 1'b1;
         end else if (wr_status && reg_wdata[FLAG_A_BIT]) begin
            compare_a_flag <= 1'b0;
         end
         if (set_p) begin
            compare_p_flag <= 1'b1;
         end else if (wr_status && reg_wdata[FLAG_P_BIT]) begin
            compare_p_flag <= 1'b0;
         end
      end
   end

   // pulse output; capture and other modes leave it low
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         timer_out <= 1'b0;
      end else if (pulse_mode) begin
         timer_out <= (counter_run_bit ? output_level_control
                       : ~output_level_control)
                      ^ output_invert;
      end else begin
         timer_out <= 1'b0;
      end
   end

   // read data, valid only in the cycle after the strobe
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         ADDR_CTRL0:    next_rdata[RUN_BIT] = counter_run_bit;
         ADDR_CTRL1:    next_rdata = timer_control_one;
         ADDR_CMPA_LO:  next_rdata = compare_a_value[7:0];
         ADDR_CMPA_HI:  next_rdata = compare_a_value[15:8];
         ADDR_CMPP:     next_rdata = compare_p_value;
         ADDR_COUNT_LO: next_rdata = count[7:0];
         ADDR_COUNT_HI: next_rdata = count[15:8];
         ADDR_STATUS: begin
            next_rdata[FLAG_A_BIT] = compare_a_flag;
            next_rdata[FLAG_P_BIT] = compare_p_flag;
         end
         default:       next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_read ? next_rdata : 8'h00;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   property p_trig_sets_run;
      pulse_mode && trig_rise |=> counter_run_bit;
   endproperty
   a_trig_sets_run: assert property (p_trig_sets_run)
      else $error("trigger edge did not set run bit");

   property p_rise_zeroes;
      counter_run_bit && !run_q |=> count == 16'h0000;
   endproperty
   a_rise_zeroes: assert property (p_rise_zeroes)
      else $error("counter not zero after run rise");

   property p_a_ends_pulse;
      a_hit && !trig_rise && !wr_ctrl0 |=> !counter_run_bit;
   endproperty
   a_a_ends_pulse: assert property (p_a_ends_pulse)
      else $error("compare A match did not stop run");

   property p_a_irq;
      a_hit |=> timer_irq && compare_a_flag;
   endproperty
   a_a_irq: assert property (p_a_irq)
      else $error("compare A match raised no interrupt");

   property p_pulse_level;
      pulse_mode && counter_run_bit |=>
         timer_out == ($past(output_level_control) ^ $past(output_invert));
   endproperty
   a_pulse_level: assert property (p_pulse_level)
      else $error("pulse output not at active level");

   property p_capture_latch;
      cap_event |=> compare_a_value == $past(count);
   endproperty
   a_capture_latch: assert property (p_capture_latch)
      else $error("capture did not latch counter");

   property p_capture_flag;
      cap_event |-> ##FLAG_D compare_a_flag;
   endproperty
   a_capture_flag: assert property (p_capture_flag)
      else $error("compare A flag late after capture");

   property p_capture_off;
      cap_mode && (out_func == CAP_OFF) |-> !cap_event;
   endproperty
   a_capture_off: assert property (p_capture_off)
      else $error("capture while disabled");

   property p_p_wrap;
      p_hit |-> count[7:0] == 8'hFF ##1 count == 16'h0000 && timer_irq;
   endproperty
   a_p_wrap: assert property (p_p_wrap)
      else $error("compare P match did not wrap counter");

   property p_hold_stopped;
      !counter_run_bit |=> count == $past(count);
   endproperty
   a_hold_stopped: assert property (p_hold_stopped)
      else $error("counter moved while stopped");

   property p_no_output_capture;
      cap_mode |=> !timer_out;
   endproperty
   a_no_output_capture: assert property (p_no_output_capture)
      else $error("output driven in capture mode");

   c_pulse_end:   cover property (a_hit ##1 !counter_run_bit);
   c_capture:     cover property (cap_event ##FLAG_D compare_a_flag);
   c_p_wrap:      cover property (p_hit && compare_p_value == 8'h00);
   c_trig_pulse:  cover property (pulse_mode && trig_rise && !counter_run_bit);
endmodule : tspc_timer

// ---- sim/tspc_pin_model.sv ----
`timescale 1ns/10ps
module tspc_pin_model (
   // clock
   input  wire logic clk_sys,
   // pins toward the timer
   output logic      ext_trigger_pin,
   output logic      capture_pin
);
   initial begin
      ext_trigger_pin = 1'b0;
      capture_pin     = 1'b0;
   end

   // pin levels move just after a clock edge and then stand
   task automatic set_pin(input bit trig, input logic lvl);
      @(posedge clk_sys);
      if (trig) begin
         ext_trigger_pin <= lvl;
      end else begin
         capture_pin <= lvl;
      end
   endtask : set_pin
endmodule : tspc_pin_model

// ---- sim/tspc_timer_tb_top.sv ----
`timescale 1ns/10ps
module tspc_timer_tb_top;
   import tspc_pkg::*;
   logic       clk_sys;
   logic       reset;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_write;
   logic       reg_read;
   logic [7:0] reg_rdata;
   logic       ext_trigger_pin;
   logic       capture_pin;
   logic       timer_out;
   logic       timer_irq;
   int         mismatches  = 0;
   int         check_count = 0;
   int         irq_count   = 0;

   tspc_timer tspc_timer_i (
      .clk_sys        (clk_sys),
      .reset          (reset),
      .reg_addr       (reg_addr),
      .reg_wdata      (reg_wdata),
      .reg_write      (reg_write),
      .reg_read       (reg_read),
      .reg_rdata      (reg_rdata),
      .ext_trigger_pin(ext_trigger_pin),
      .capture_pin    (capture_pin),
      .timer_out      (timer_out),
      .timer_irq      (timer_irq)
   );

   tspc_pin_model tspc_pin_model_i (
      .clk_sys        (clk_sys),
      .ext_trigger_pin(ext_trigger_pin),
      .capture_pin    (capture_pin)
   );

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (timer_irq === 1'b1) begin
         irq_count <= irq_count + 1;
      end
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      @(negedge clk_sys);
      d = {8'h00, reg_rdata};
   endtask : rd

   task automatic rd16(input logic [2:0] a, output logic [15:0] d);
      logic [15:0] h;
      rd(a, d);
      rd(a + 3'h1, h);
      d = {h[7:0], d[7:0]};
   endtask : rd16

   task automatic wait_irq(input int base, input int lim, output int n);
      n = 0;
      while (irq_count == base && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      if (n == lim) begin
         mismatches++;
         $display("ERROR t=%0t irq wait %h %h", $time, n, lim);
         summarize();
      end
   endtask : wait_irq

   task automatic t_reset_vals;
      logic [15:0] d;
      rd(ADDR_CTRL1, d);
      chk(d, {8'h00, CTRL1_RESET});
      rd16(ADDR_CMPA_LO, d);
      chk(d, CMPA_RESET);
      rd(ADDR_CMPP, d);
      chk(d, {8'h00, CMPP_RESET});
      rd16(ADDR_COUNT_LO, d);
      chk(d, COUNT_RESET);
      chk({15'h0, timer_out}, 16'h0000);
   endtask : t_reset_vals

   task automatic t_soft_pulse;
      logic [15:0] d;
      int          b;
      int          n;
      wr(ADDR_CMPP, 8'h01);
      wr(ADDR_CMPA_LO, 8'h05);
      wr(ADDR_CTRL1, 8'hB9);
      b = irq_count;
      wr(ADDR_CTRL0, 8'h08);
      step(3);
      chk({15'h0, timer_out}, 16'h0001);
      wait_irq(b, 60, n);
      chk(16'(n >= 10 && n <= 22), 16'h0001);
      step(2);
      chk({15'h0, timer_out}, 16'h0000);
      rd(ADDR_CTRL0, d);
      chk(d, 16'h0000);
      rd16(ADDR_COUNT_LO, d);
      chk(d, 16'h0005);
      rd(ADDR_STATUS, d);
      chk(d, 16'h0001);
   endtask : t_soft_pulse

   task automatic t_trig_pulse;
      logic [15:0] c1;
      logic [15:0] c2;
      int          b;
      wr(ADDR_STATUS, 8'h03);
      wr(ADDR_CMPA_HI, 8'h01);
      wr(ADDR_CTRL1, 8'hB0);
      step(2);
      chk({15'h0, timer_out}, 16'h0001);
      b = irq_count;
      tspc_pin_model_i.set_pin(1'b1, 1'b1);
      step(10);
      chk({15'h0, timer_out}, 16'h0000);
      tspc_pin_model_i.set_pin(1'b1, 1'b0);
      rd(ADDR_CTRL0, c1);
      chk(c1, 16'h0008);
      wr(ADDR_CTRL0, 8'h00);
      step(2);
      chk({15'h0, timer_out}, 16'h0001);
      rd16(ADDR_COUNT_LO, c1);
      step(20);
      rd16(ADDR_COUNT_LO, c2);
      chk(c2, c1);
      chk(16'(irq_count - b), 16'h0000);
   endtask : t_trig_pulse

   task automatic t_capture;
      logic [15:0] ex [4] = '{16'h1, 16'h1, 16'h2, 16'h0};
      logic [15:0] a;
      logic [15:0] c;
      int          b;
      wr(ADDR_STATUS, 8'h03);
      wr(ADDR_CMPP, 8'h00);
      for (int e = 0; e < 4; e++) begin
         wr(ADDR_CTRL1, {2'h1, 2'(e), 4'hC});
         if (e == 0) begin
            wr(ADDR_CTRL0, 8'h08);
         end
         b = irq_count;
         tspc_pin_model_i.set_pin(1'b0, 1'b1);
         step(12);
         tspc_pin_model_i.set_pin(1'b0, 1'b0);
         step(20);
         chk(16'(irq_count - b), ex[e]);
         chk({15'h0, timer_out}, 16'h0000);
         if (e == 0) begin
            rd16(ADDR_CMPA_LO, a);
            rd16(ADDR_COUNT_LO, c);
            chk(16'(a != 0 && a < c), 16'h0001);
         end
      end
      rd16(ADDR_COUNT_LO, a);
      step(20);
      rd16(ADDR_COUNT_LO, c);
      chk(16'(c > a), 16'h0001);
   endtask : t_capture

   task automatic t_cap_src;
      logic [15:0] a0;
      logic [15:0] a1;
      int          b;
      int          n;
      wr(ADDR_CTRL1, 8'h42);
      rd16(ADDR_CMPA_LO, a0);
      b = irq_count;
      tspc_pin_model_i.set_pin(1'b0, 1'b1);
      step(12);
      tspc_pin_model_i.set_pin(1'b0, 1'b0);
      step(10);
      chk(16'(irq_count - b), 16'h0000);
      tspc_pin_model_i.set_pin(1'b1, 1'b1);
      wait_irq(b, 9, n);
      tspc_pin_model_i.set_pin(1'b1, 1'b0);
      rd16(ADDR_CMPA_LO, a1);
      chk(16'(a1 != a0), 16'h0001);
   endtask : t_cap_src

   task automatic t_wrap;
      logic [15:0] d;
      int          b;
      int          n;
      wr(ADDR_CTRL0, 8'h00);
      wr(ADDR_CTRL1, 8'h70);
      wr(ADDR_CMPP, 8'h01);
      wr(ADDR_STATUS, 8'h03);
      b = irq_count;
      wr(ADDR_CTRL0, 8'h08);
      wait_irq(b, 1100, n);
      chk(16'(n >= 1015 && n <= 1035), 16'h0001);
      rd(ADDR_STATUS, d);
      chk(d, 16'h0002);
      rd16(ADDR_COUNT_LO, d);
      chk(16'(d < 16'h0010), 16'h0001);
   endtask : t_wrap

   initial begin
      reset     = 1'b1;
      reg_addr  = 3'h0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read  = 1'b0;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset_vals();
      t_soft_pulse();
      t_trig_pulse();
      t_capture();
      t_cap_src();
      t_wrap();
      summarize();
   end
endmodule : tspc_timer_tb_top
